// *** core/sbf_core.sv ***
/*
  Bit-rate generator, transmit/receive buffer flags and mode fault for a
  byte-wide serial interface, with an APB register slave.
  Assumes a separate shifter that takes xfer_start_o/tx_byte_o, counts
  bit_edge_o and reports xfer_done_i with rx_byte_i, all on clk_i.
*/
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Rate bits 6:4 pick prescale divisor, code plus one, one to eight.
// - Prescaler runs from bus clock and feeds the second divider.
// - Rate bits 2:0 pick divider two to the power code plus one.
// - Second divider output is the serial bit clock in master mode.
// - Rate register readable and writable at any time, never blocked.
// - Flag bits 6,3,2,1,0 read zero; flag writes change nothing.
// - Receive-full bit 7 sets when a transfer completes.
// - Receive-full clears by flag read while set, then data read.
// - Transmit-empty bit 5 is one when the transmit buffer has room.
// - Transmit-empty clears by flag read while set, then data write.
// - Data writes without a preceding flag read showing empty are discarded.
// - Transmit request raised while transmit-empty and its enable are set.
// - Transmit-empty sets when a byte moves from buffer to shifter.
// - Idle interface moves a written byte so empty sets within two cycles.
// - On transfer end a queued byte moves; with none, nothing moves.
// - Mode-fault bit 4 sets when master sees select input low.
// - Mode fault only with master, fault detect on, select output off.
// - Mode fault clears by flag read while set, then first control register write.
// - Disable aborts transfer, empties buffers, clears receive, sets empty.
// - Master select one means master, zero means slave.
// - Unread receive byte is kept; a newer byte is lost silently.
module sbf_core (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic en_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Shifter side
  input wire logic xfer_done_i,
  input wire logic [7:0] rx_byte_i,
  output logic xfer_start_o,
  output logic [7:0] tx_byte_o,
  output logic [7:0] ctrl1_o,
  // Link side
  input wire logic ss_n_i,
  output logic bit_clk_o,
  output logic bit_edge_o,
  output logic tx_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  logic acc;
  logic setup;
  logic hit_c1;
  logic hit_c2;
  logic hit_rt;
  logic hit_fl;
  logic hit_dt;
  logic mapped;
  logic wr;
  logic rd;
  logic [7:0] ctrl1_ff;
  logic [7:0] ctrl2_ff;
  logic [7:0] rate_ff;
  logic [7:0] rd_ff;
  logic [7:0] nxt_rd;
  logic [7:0] flags;
  logic [7:0] rx_buf_ff;
  logic [7:0] tx_buf_ff;
  logic [7:0] shift_byte_ff;
  logic rx_full_ff;
  logic rx_arm_ff;
  logic tx_full_ff;
  logic tx_arm_ff;
  logic mode_fault_flag_ff;
  logic mode_fault_flag_arm_ff;
  logic xfer_start_ff;
  logic data_wr_ok;
  logic move;
  logic mode_fault_flag_det;
  sbf_pkg::sbf_mode_s mode;
  sbf_pkg::sbf_xfer_e xs_ff;

  assign acc = psel_i & penable_i & en_i;
  assign setup = psel_i & ~penable_i;
  assign hit_c1 = (paddr_i == sbf_pkg::OFS_CTRL1);
  assign hit_c2 = (paddr_i == sbf_pkg::OFS_CTRL2);
  assign hit_rt = (paddr_i == sbf_pkg::OFS_RATE);
  assign hit_fl = (paddr_i == sbf_pkg::OFS_FLAGS);
  assign hit_dt = (paddr_i == sbf_pkg::OFS_DATA);
  assign mapped = hit_c1 | hit_c2 | hit_rt | hit_fl | hit_dt;
  assign wr = acc & pwrite_i & mapped;
  assign rd = acc & ~pwrite_i & mapped;
  // No wait states: every access ends in one access cycle unless frozen
  assign pready_o = en_i;
  assign pslverr_o = acc & ~mapped;
  assign prdata_o = {24'h00_0000, rd_ff};

  assign mode.en = ctrl1_ff[sbf_pkg::C1_EN];
  assign mode.txie = ctrl1_ff[sbf_pkg::C1_TXIE];
  assign mode.master_select = ctrl1_ff[sbf_pkg::C1_MASTER_SELECT];
  assign mode.select_output_enable = ctrl1_ff[sbf_pkg::C1_SELECT_OUTPUT_ENABLE];
  assign mode.fden = ctrl2_ff[sbf_pkg::C2_FDEN];
  assign ctrl1_o = ctrl1_ff;

  assign flags = {rx_full_ff, 1'b0, ~tx_full_ff, mode_fault_flag_ff, 4'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Control and rate registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl1_ff <= sbf_pkg::CTRL1_RST;
      ctrl2_ff <= sbf_pkg::CTRL2_RST;
      rate_ff <= sbf_pkg::RATE_RST;
    end else if (wr) begin
      if (hit_c1) begin
        ctrl1_ff <= pwdata_i[7:0];
      end
      if (hit_c2) begin
        ctrl2_ff <= pwdata_i[7:0] & sbf_pkg::C2_MASK;
      end
      if (hit_rt) begin
        rate_ff <= pwdata_i[7:0] & sbf_pkg::RT_MASK;
      end
    end
  end

  // Read data is sampled in the setup cycle; arming uses this same value,
  // so software is only armed by a flag it actually saw.
  always_comb begin
    nxt_rd = 8'h00;
    if (hit_c1) begin
      nxt_rd = ctrl1_ff;
    end else if (hit_c2) begin
      nxt_rd = ctrl2_ff;
    end else if (hit_rt) begin
      nxt_rd = rate_ff;
    end else if (hit_fl) begin
      nxt_rd = flags;
    end else if (hit_dt) begin
      nxt_rd = rx_buf_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_ff <= 8'h00;
    end else if (en_i && setup) begin
      rd_ff <= pwrite_i ? 8'h00 : nxt_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer and shifter occupancy
  assign data_wr_ok = wr & hit_dt & tx_arm_ff & mode.en;
  assign move = mode.en & tx_full_ff & ((xs_ff == sbf_pkg::XS_IDLE) | xfer_done_i);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_arm_ff <= 1'b0;
    end else if (en_i) begin
      if (!mode.en) begin
        tx_arm_ff <= 1'b0;
      end else if (rd && hit_fl && rd_ff[sbf_pkg::FL_TXE]) begin
        tx_arm_ff <= 1'b1;
      end else if (wr && hit_dt) begin
        tx_arm_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_full_ff <= 1'b0;
      tx_buf_ff <= 8'h00;
    end else if (en_i) begin
      if (!mode.en) begin
        tx_full_ff <= 1'b0;
      end else if (data_wr_ok) begin
        tx_full_ff <= 1'b1;
        tx_buf_ff <= pwdata_i[7:0];
      end else if (move) begin
        tx_full_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      xs_ff <= sbf_pkg::XS_IDLE;
      xfer_start_ff <= 1'b0;
      shift_byte_ff <= 8'h00;
    end else if (en_i) begin
      xfer_start_ff <= move;
      if (move) begin
        shift_byte_ff <= tx_buf_ff;
      end
      if (!mode.en) begin
        xs_ff <= sbf_pkg::XS_IDLE;
      end else begin
        unique case (xs_ff)
          sbf_pkg::XS_IDLE: begin
            if (move) begin
              xs_ff <= sbf_pkg::XS_BUSY;
            end
          end
          sbf_pkg::XS_BUSY: begin
            if (xfer_done_i && !move) begin
              xs_ff <= sbf_pkg::XS_IDLE;
            end
          end
          default: begin
            xs_ff <= sbf_pkg::XS_IDLE;
          end
        endcase
      end
    end
  end

  assign xfer_start_o = xfer_start_ff;
  assign tx_byte_o = shift_byte_ff;
  assign tx_irq_o = ~tx_full_ff & mode.txie;

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_full_ff <= 1'b0;
      rx_buf_ff <= 8'h00;
    end else if (en_i) begin
      if (!mode.en) begin
        rx_full_ff <= 1'b0;
      end else if (xfer_done_i) begin
        rx_full_ff <= 1'b1;
        if (!rx_full_ff) begin
          rx_buf_ff <= rx_byte_i;
        end
      end else if (rd && hit_dt && rx_arm_ff) begin
        rx_full_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_arm_ff <= 1'b0;
    end else if (en_i) begin
      if (!mode.en) begin
        rx_arm_ff <= 1'b0;
      end else if (rd && hit_fl && rd_ff[sbf_pkg::FL_RXF]) begin
        rx_arm_ff <= 1'b1;
      end else if (rd && hit_dt) begin
        rx_arm_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode fault
  assign mode_fault_flag_det = mode.master_select & mode.fden & ~mode.select_output_enable & ~ss_n_i;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_fault_flag_ff <= 1'b0;
      mode_fault_flag_arm_ff <= 1'b0;
    end else if (en_i) begin
      if (mode_fault_flag_det) begin
        mode_fault_flag_ff <= 1'b1;
      end else if (wr && hit_c1 && mode_fault_flag_arm_ff) begin
        mode_fault_flag_ff <= 1'b0;
      end
      if (rd && hit_fl && rd_ff[sbf_pkg::FL_MODE_FAULT_FLAG]) begin
        mode_fault_flag_arm_ff <= 1'b1;
      end else if (wr && hit_c1) begin
        mode_fault_flag_arm_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit-rate generator
  logic [2:0] pre_cnt_ff;
  logic [6:0] div_cnt_ff;
  logic bit_clk_ff;
  logic run;
  logic pre_wrap;
  logic div_last;
  logic [7:0] half;

  assign run = mode.en & mode.master_select & (xs_ff == sbf_pkg::XS_BUSY);
  assign pre_wrap = (pre_cnt_ff == rate_ff[sbf_pkg::RT_PRE_LSB +: 3]);
  // Half a bit period is two to the power code prescaler ticks
  assign half = 8'h01 << rate_ff[sbf_pkg::RT_DIV_LSB +: 3];
  assign div_last = ({1'b0, div_cnt_ff} == 8'(half - 8'h01));
  // The restart cycle resets the counters, so no toggle and no edge pulse there
  assign bit_edge_o = run & ~xfer_start_ff & pre_wrap & div_last;
  assign bit_clk_o = bit_clk_ff;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pre_cnt_ff <= 3'h0;
      div_cnt_ff <= 7'h00;
      bit_clk_ff <= 1'b0;
    end else if (en_i) begin
      if (!run || xfer_start_ff) begin
        pre_cnt_ff <= 3'h0;
        div_cnt_ff <= 7'h00;
        bit_clk_ff <= 1'b0;
      end else if (pre_wrap) begin
        pre_cnt_ff <= 3'h0;
        if (div_last) begin
          div_cnt_ff <= 7'h00;
          bit_clk_ff <= ~bit_clk_ff;
        end else begin
          div_cnt_ff <= div_cnt_ff + 7'h01;
        end
      end else begin
        pre_cnt_ff <= pre_cnt_ff + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i || !en_i);

  property p_rate_rw;
    wr && hit_rt |=> rate_ff == ($past(pwdata_i[7:0]) & sbf_pkg::RT_MASK);
  endproperty
  a_rate_rw: assert property (p_rate_rw) else $error("rate write lost");

  property p_flags_zero;
    acc && !pwrite_i && hit_fl |-> (rd_ff & sbf_pkg::FL_ZERO_MASK) == 8'h00;
  endproperty
  a_flags_zero: assert property (p_flags_zero) else $error("flag pad bits set");

  property p_rx_set;
    mode.en && xfer_done_i |=> rx_full_ff;
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("receive full not set");

  property p_rx_hold;
    rx_full_ff && mode.en && !(rd && hit_dt && rx_arm_ff) |=> rx_full_ff;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("receive full dropped");

  property p_tx_drop;
    wr && hit_dt && !tx_arm_ff && !tx_full_ff |=> !tx_full_ff;
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("unarmed write taken");

  property p_irq;
    tx_irq_o == (flags[sbf_pkg::FL_TXE] && ctrl1_ff[sbf_pkg::C1_TXIE]);
  endproperty
  a_irq: assert property (p_irq) else $error("transmit request wrong");

  property p_idle_move;
    data_wr_ok && xs_ff == sbf_pkg::XS_IDLE && mode.en ##1 mode.en
      |-> ##1 !tx_full_ff && xs_ff == sbf_pkg::XS_BUSY;
  endproperty
  a_idle_move: assert property (p_idle_move) else $error("idle move late");

  property p_mode_fault_flag_gate;
    !(mode.master_select && mode.fden && !mode.select_output_enable) && !mode_fault_flag_ff |=> !mode_fault_flag_ff;
  endproperty
  a_mode_fault_flag_gate: assert property (p_mode_fault_flag_gate) else $error("mode fault set");

  property p_disable;
    !mode.en |=> !tx_full_ff && !rx_full_ff && xs_ff == sbf_pkg::XS_IDLE;
  endproperty
  a_disable: assert property (p_disable) else $error("disable incomplete");

  c_rx_set: cover property (xfer_done_i && !rx_full_ff && mode.en);
  c_tx_drop: cover property (wr && hit_dt && !tx_arm_ff);
  c_mode_fault_flag: cover property (!mode_fault_flag_ff ##1 mode_fault_flag_ff);
  c_chain: cover property (xfer_done_i && tx_full_ff && mode.en);

endmodule // sbf_core

// *** shared/sbf_pkg.sv ***
/*
  Constants, field layout and types for the serial bit-rate and status flag block.
  Assumes an APB master with byte addresses and 32-bit data.
*/
package sbf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_DATA = 8'h10;
  // First control register fields
  localparam int C1_EN = 6;
  localparam int C1_TXIE = 5;
  localparam int C1_MASTER_SELECT = 4;
  localparam int C1_SELECT_OUTPUT_ENABLE = 1;
  // Second control register fields
  localparam int C2_FDEN = 4;
  localparam logic [7:0] C2_MASK = 8'h1B;
  // Rate register fields
  localparam int RT_PRE_LSB = 4;
  localparam int RT_DIV_LSB = 0;
  localparam logic [7:0] RT_MASK = 8'h77;
  // Flag register fields
  localparam int FL_RXF = 7;
  localparam int FL_TXE = 5;
  localparam int FL_MODE_FAULT_FLAG = 4;
  localparam logic [7:0] FL_ZERO_MASK = 8'h4F;
  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  // Idle write to shifter move bound, in bus cycles
  localparam int TX_MOVE_CYC = 2;

  typedef struct packed {
    logic en;
    logic txie;
    logic master_select;
    logic select_output_enable;
    logic fden;
  } sbf_mode_s;

  typedef enum logic [1:0] {
    XS_IDLE = 2'b01,
    XS_BUSY = 2'b10
  } sbf_xfer_e;
endpackage

// *** test/sbf_shift_model.sv ***
/*
  Shifter model for the far side of the flag block's shifter port.
  Assumes the block's bit_edge_o, xfer_start_o and tx_byte_o on one clock.
*/
`timescale 1ns/1ns
module sbf_shift_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // From the block
  input wire logic xfer_start_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic bit_edge_i,
  input wire logic [7:0] ctrl1_i,
  // To the block
  output logic xfer_done_o,
  output logic [7:0] rx_byte_o
);
  logic busy = 1'b0;
  logic [7:0] pat = 8'h00;
  int edges = 0;
  // A slave has no bit clock here, so one edge per cycle stands in for it
  always @(posedge clk_i) begin
    xfer_done_o <= 1'b0;
    pat <= pat + 8'h01;
    // Receive byte is only defined in the done cycle
    rx_byte_o <= pat ^ 8'h5a;
    if (srst_i || !ctrl1_i[sbf_pkg::C1_EN]) begin
      busy <= 1'b0;
    end else if (xfer_start_i) begin
      busy <= 1'b1;
      edges <= 0;
    end else if (busy && (bit_edge_i || !ctrl1_i[sbf_pkg::C1_MASTER_SELECT])) begin
      edges <= edges + 1;
      if (edges == 15) begin
        busy <= 1'b0;
        xfer_done_o <= 1'b1;
        rx_byte_o <= ~tx_byte_i;
      end
    end
  end
endmodule // sbf_shift_model

// *** test/tb_sbf_core.sv ***
/*
  Bench for sbf_core: APB master tasks, a queue model of the buffers and flags.
  Assumes the shifter model on the shifter port and one 250 MHz clock.
*/
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_sbf_core;
  logic clk, srst, en, psel, penable, pwrite, pslverr, pready, done, start;
  logic bclk, bedge, irq, ss_n, err, m_rxf;
  logic [7:0] paddr, rxb, txb, ctrl1, q, rate, d, m_rx;
  logic [31:0] pwdata, prdata;
  logic [31:0] seed = 32'h2959_e962;
  logic [15:0] cnt = 16'h0000;
  logic [15:0] gap;
  logic [7:0] txq[$];
  logic [7:0] mf_c1[4] = '{8'h50, 8'h40, 8'h52, 8'h50};
  logic [7:0] mf_c2[4] = '{8'h10, 8'h10, 8'h10, 8'h00};
  int num_checks = 0, failures = 0, starts = 0, n0;

  sbf_core i_dut (.clk_i(clk), .srst_i(srst), .en_i(en), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .xfer_done_i(done), .rx_byte_i(rxb),
    .xfer_start_o(start), .tx_byte_o(txb), .ctrl1_o(ctrl1), .ss_n_i(ss_n),
    .bit_clk_o(bclk), .bit_edge_o(bedge), .tx_irq_o(irq));
  sbf_shift_model i_shift (.clk_i(clk), .srst_i(srst), .xfer_start_i(start),
    .tx_byte_i(txb), .bit_edge_i(bedge), .ctrl1_i(ctrl1), .xfer_done_o(done),
    .rx_byte_o(rxb));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Gap between bit edges and count of moves into the shifter
  always @(posedge clk) begin
    if (bedge === 1'b1) begin
      gap <= cnt;
      cnt <= 16'h0001;
    end else begin
      cnt <= cnt + 16'h0001;
    end
    if (start === 1'b1) starts <= starts + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] half(input logic [7:0] r);
    return (16'(r[6:4]) + 16'h0001) << r[2:0];
  endfunction

  // Buffer has room while at most the shifting byte is held
  function automatic logic [7:0] m_flags();
    return {m_rxf, 1'b0, txq.size() < 2, 5'h00};
  endfunction

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One idle cycle after each transfer keeps every driver change in its own step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      failures++;
      test_done();
    end
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdf();
    apb(1'b0, sbf_pkg::OFS_FLAGS, 8'h00);
  endtask

  task automatic send(input logic [7:0] b);
    rdf();
    apb(1'b1, sbf_pkg::OFS_DATA, b);
    txq.push_back(b);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 40000) begin
        failures++;
        test_done();
      end
    end
    repeat (2) @(posedge clk);
    if (!m_rxf) begin
      m_rx = ~txq[0];
      m_rxf = 1'b1;
    end
    void'(txq.pop_front());
  endtask

  task automatic take_rx();
    rdf();
    `CHK("flags_rx", m_flags(), q)
    apb(1'b0, sbf_pkg::OFS_DATA, 8'h00);
    `CHK("rx_data", m_rx, q)
    m_rxf = 1'b0;
    rdf();
    `CHK("flags_clr", m_flags(), q)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ss_n = 1'b1;
    m_rxf = 1'b0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rdf();
    `CHK("flags_rst", 8'h20, q)
    apb(1'b1, sbf_pkg::OFS_FLAGS, 8'hff);
    apb(1'b0, sbf_pkg::OFS_RATE, 8'h00);
    `CHK("rate_rst", sbf_pkg::RATE_RST, q)
    rdf();
    `CHK("flags_wr", 8'h20, q)
    apb(1'b0, 8'h14, 8'h00);
    `CHK("unmapped", 1'b1, err)
    $display("test reset done");
    apb(1'b1, sbf_pkg::OFS_CTRL1, 8'h50);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      rate = (i == 0) ? 8'h00 : (i == 1) ? 8'h77 : seed[7:0] & 8'h73;
      d = seed[15:8];
      apb(1'b1, sbf_pkg::OFS_RATE, rate);
      send(d);
      @(posedge clk);
      `CHK("tx_byte", d, txb)
      rdf();
      `CHK("flags_busy", m_flags(), q)
      apb(1'b0, sbf_pkg::OFS_RATE, 8'h00);
      `CHK("rate_busy", rate, q)
      wait_done();
      `CHK("half_period", half(rate), gap)
      take_rx();
    end
    $display("test rate done");
    // The last flag read armed the data port; a disable cycle disarms it
    apb(1'b1, sbf_pkg::OFS_CTRL1, 8'h10);
    apb(1'b1, sbf_pkg::OFS_CTRL1, 8'h50);
    n0 = starts;
    apb(1'b1, sbf_pkg::OFS_DATA, 8'h3c);
    repeat (8) @(posedge clk);
    `CHK("no_start", n0, starts)
    apb(1'b1, sbf_pkg::OFS_RATE, 8'h01);
    apb(1'b1, sbf_pkg::OFS_CTRL1, 8'h70);
    `CHK("irq_on", 1'b1, irq)
    send(8'ha1);
    @(posedge clk);
    send(8'hb2);
    rdf();
    `CHK("flags_full", m_flags(), q)
    `CHK("irq_off", 1'b0, irq)
    wait_done();
    `CHK("tx_next", 8'hb2, txb)
    `CHK("irq_back", 1'b1, irq)
    n0 = starts;
    wait_done();
    repeat (8) @(posedge clk);
    `CHK("no_move", n0, starts)
    take_rx();
    $display("test queue done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, sbf_pkg::OFS_CTRL1, mf_c1[i]);
      apb(1'b1, sbf_pkg::OFS_CTRL2, mf_c2[i]);
      ss_n <= 1'b0;
      repeat (3) @(posedge clk);
      ss_n <= 1'b1;
      rdf();
      `CHK("mode_fault_flag", i == 0, q[4])
    end
    $display("test fault done");
    apb(1'b1, sbf_pkg::OFS_RATE, 8'h33);
    send(8'h5e);
    wait_done();
    send(8'h6f);
    apb(1'b1, sbf_pkg::OFS_CTRL1, 8'h10);
    txq.delete();
    m_rxf = 1'b0;
    rdf();
    `CHK("flags_off", m_flags(), q)
    `CHK("bclk_off", 1'b0, bclk)
    $display("test disable done");
    test_done();
  end
endmodule // tb_sbf_core
